// file: design/link_ctrl_pkg.sv
// Shared constants for the port link control and link status register bank.
// Assumes a 32-bit register port with one aligned word per register.
package link_ctrl_pkg;

	// Byte addresses of the registers on the register port.
	localparam logic [7:0] LINK_CTRL_STAT_ADDR = 8'hD0;  // Control low half, status high half.
	localparam logic [7:0] IRQ_STATUS_ADDR     = 8'hE0;  // Sticky event bits, read only.
	localparam logic [7:0] IRQ_CLEAR_ADDR      = 8'hE4;  // Write one to clear, reads zero.
	localparam logic [7:0] IRQ_ENABLE_ADDR     = 8'hE8;  // Per-event enable.

	// Link control field positions.
	localparam int ASPM_LO          = 0;   // Power-state entry control, two bits.
	localparam int COMPL_BOUND_BIT  = 3;   // Always reads zero on a switch port.
	localparam int LINK_DIS_BIT     = 4;   // Link disable.
	localparam int RETRAIN_BIT      = 5;   // Retrain request, reads zero.
	localparam int COMMON_CLK_BIT   = 6;   // Common reference clock.
	localparam int EXT_SYNC_BIT     = 7;   // Extended synchronisation.
	localparam int AUTO_WIDTH_BIT   = 9;   // Autonomous width change disable.
	localparam int DSP_CTRL_LO      = 10;  // Downstream-only storage, bits 11:10.

	// Link status field positions within the 32-bit word.
	localparam int SPEED_LO         = 16;  // Negotiated rate, bits 19:16.
	localparam int WIDTH_LO         = 20;  // Negotiated width, bits 25:20.
	localparam int TRAIN_ERR_BIT    = 26;  // Training error.
	localparam int TRAINING_BIT     = 27;  // Training in progress.
	localparam int SLOT_CLK_BIT     = 28;  // Slot clock configuration.
	localparam int DL_ACTIVE_BIT    = 29;  // Data link active.

	// Power-state entry control encodings.
	localparam logic [1:0] ASPM_OFF     = 2'h0;
	localparam logic [1:0] ASPM_L0S     = 2'h1;
	localparam logic [1:0] ASPM_L1      = 2'h2;
	localparam logic [1:0] ASPM_BOTH    = 2'h3;

	// Values after reset, and the two rate encodings.
	localparam logic [1:0] ASPM_RESET   = 2'h0;
	localparam logic [3:0] SPEED_RESET  = 4'h2;   // 5.0 Gb/s.
	localparam logic [3:0] SPEED_2G5    = 4'h1;
	localparam logic [3:0] SPEED_5G0    = 4'h2;
	localparam logic [5:0] WIDTH_RESET  = 6'h01;  // Single lane.

	// Ordered-set counts sent on power-state exit with extended synchronisation set.
	localparam logic [12:0] EXT_FTS_COUNT = 13'h1000;  // 4096 sets leaving L0s.
	localparam logic [12:0] EXT_TS1_COUNT = 13'h0400;  // 1024 sets leaving L1.

	// Interrupt event bit positions.
	localparam int EV_TRAIN_ERR  = 0;  // Training failed.
	localparam int EV_TRAIN_DONE = 1;  // Training reached L0.
	localparam int EV_DL_CHANGE  = 2;  // Data link active changed.
	localparam int EV_RATE_CHG   = 3;  // Negotiated rate or width changed.
	localparam int EV_COUNT      = 4;

	// Edges of the strap synchroniser that must pass before the strap is trusted.
	localparam logic [1:0] STRAP_SETTLE = 2'h3;

endpackage

// file: design/link_ctrl_regs.sv
// Link control and link status register bank of one switch port, with event interrupt.
// Assumes link training and data link logic on the same clock, a strap pin from outside,
// and a register port whose read data stand in the cycle after the read strobe.
//
// Notes on behaviour
// [RULE_01] Power control: 00 off, 01 L0s, 10 L1, 11 both.
// [RULE_02] Receiver may always enter L0s.
// [RULE_03] Completion boundary bit always reads zero.
// [RULE_04] Link disable: upstream zero, downstream stored.
// [RULE_05] Retrain: upstream ignored, downstream starts retraining.
// [RULE_06] Retrain bit always reads zero.
// [RULE_07] Common clock bit stored, resets zero.
// [RULE_08] Extended sync: 4096 FTS, 1024 TS1.
// [RULE_09] Bits 11:10 downstream storage, upstream zero.
// [RULE_10] Speed field reports negotiated rate, resets 0010.
// [RULE_11] Width field reports trained width, resets 0001.
// [RULE_12] Training error set on fail, cleared on success.
// [RULE_13] Training bit high while training runs.
// [RULE_14] Slot clock bit follows strap after reset.
// [RULE_15] Slot clock replaceable by management load.
// [RULE_16] Link active bit mirrors data link active.
// [RULE_17] Retrain write gives one-cycle request, nothing stored.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ns

module link_ctrl_regs #(
	parameter bit          IS_UPSTREAM   = 1'b0,     // One for the upstream port.
	parameter logic [12:0] BASE_FTS      = 13'h0080, // Exit sets without extended sync.
	parameter logic [12:0] BASE_TS1      = 13'h0010  // Exit sets without extended sync.
) (
	// Clock and reset.
	input  wire logic        CLK_IN,
	input  wire logic        SYS_RST_IN,
	// Register port.
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic [31:0] WR_DATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [31:0] RD_DATA_OUT,
	// Link training and data link status, same clock.
	input  wire logic [3:0]  LINK_SPEED_IN,
	input  wire logic [5:0]  LINK_WIDTH_IN,
	input  wire logic        TRAIN_ACTIVE_IN,
	input  wire logic        TRAIN_FAIL_IN,
	input  wire logic        TRAIN_OK_IN,
	input  wire logic        DL_ACTIVE_IN,
	// Slot clock strap pin and management override.
	input  wire logic        SLOT_CLOCK_STRAP_IN,
	input  wire logic        SLOT_CLK_LOAD_IN,
	input  wire logic        SLOT_CLK_VAL_IN,
	// Controls to the link training logic.
	output logic             ASPM_L0S_EN_OUT,
	output logic             ASPM_L1_EN_OUT,
	output logic             RX_L0S_ALLOWED_OUT,
	output logic             LINK_DISABLE_OUT,
	output logic             RETRAIN_REQ_OUT,
	output logic             COMMON_CLK_OUT,
	output logic             AUTO_WIDTH_DIS_OUT,
	output logic      [12:0] FTS_COUNT_OUT,
	output logic      [12:0] TS1_COUNT_OUT,
	output logic             SLOT_CLK_OUT,
	// Interrupt.
	output logic             IRQ_OUT
);

	// A zero count would leave the link unable to leave a low-power state.
	initial begin
		if (BASE_FTS == 13'h0000 || BASE_TS1 == 13'h0000) begin
			$error("Exit ordered-set counts must be nonzero.");
		end
	end

	// Every flip-flop of the block lives in this one struct.
	typedef struct packed {
		logic [1:0]          aspm;        // Power-state entry control.
		logic                link_dis;    // Link disable, downstream only.
		logic                retrain;     // One-cycle retrain request.
		logic                common_clk;  // Common reference clock.
		logic                ext_sync;    // Extended synchronisation.
		logic                auto_width;  // Autonomous width change disable.
		logic [1:0]          dsp_ctrl;    // Downstream-only storage bits.
		logic [3:0]          speed;       // Negotiated rate.
		logic [5:0]          width;       // Negotiated width.
		logic                train_err;   // Training error.
		logic                training;    // Training in progress.
		logic                dl_active;   // Data link active.
		logic                strap_s1;    // Strap synchroniser, first stage.
		logic                strap_s2;    // Strap synchroniser, second stage.
		logic [1:0]          strap_cnt;   // Settling count after reset.
		logic                slot_clk;    // Slot clock configuration.
		logic [3:0]          ev_status;   // Sticky events.
		logic [3:0]          ev_enable;   // Event enables.
		logic                irq;         // Interrupt level.
		logic                rx_l0s;      // Receiver L0s permission.
		logic [12:0]         fts_cnt;     // FTS sets on L0s exit.
		logic [12:0]         ts1_cnt;     // TS1 sets on L1 exit.
		logic [31:0]         rd_data;     // Read data, valid one cycle.
	} state_s;

	state_s s_q;  // Registered state.
	state_s s_d;  // Next state.

	// Builds the combined control and status word as software sees it.
	function automatic logic [31:0] link_word(input state_s s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[link_ctrl_pkg::ASPM_LO +: 2] = s.aspm;       // RULE_01
		w[link_ctrl_pkg::COMPL_BOUND_BIT] = 1'b0;      // RULE_03
		w[link_ctrl_pkg::LINK_DIS_BIT] = s.link_dis;   // RULE_04
		w[link_ctrl_pkg::RETRAIN_BIT] = 1'b0;          // RULE_06
		w[link_ctrl_pkg::COMMON_CLK_BIT] = s.common_clk;
		w[link_ctrl_pkg::EXT_SYNC_BIT] = s.ext_sync;
		w[link_ctrl_pkg::AUTO_WIDTH_BIT] = s.auto_width;
		w[link_ctrl_pkg::DSP_CTRL_LO +: 2] = s.dsp_ctrl;
		w[link_ctrl_pkg::SPEED_LO +: 4] = s.speed;
		w[link_ctrl_pkg::WIDTH_LO +: 6] = s.width;
		w[link_ctrl_pkg::TRAIN_ERR_BIT] = s.train_err;
		w[link_ctrl_pkg::TRAINING_BIT] = s.training;
		w[link_ctrl_pkg::SLOT_CLK_BIT] = s.slot_clk;
		w[link_ctrl_pkg::DL_ACTIVE_BIT] = s.dl_active;
		return w;
	endfunction

	// Write decode, shared by the control and the interrupt registers.
	logic wr_link;   // Write to the link control word.
	logic wr_clear;  // Write to the event clear register.
	logic wr_enable; // Write to the event enable register.
	assign wr_link   = WR_IN && (ADDR_IN == link_ctrl_pkg::LINK_CTRL_STAT_ADDR);
	assign wr_clear  = WR_IN && (ADDR_IN == link_ctrl_pkg::IRQ_CLEAR_ADDR);
	assign wr_enable = WR_IN && (ADDR_IN == link_ctrl_pkg::IRQ_ENABLE_ADDR);

	// Next-state logic for the whole block.
	always_comb begin
		logic [3:0] events;  // Events raised this cycle.
		events = 4'h0;
		s_d = s_q;

		// Retrain is a strobe; it falls on the cycle after it rose.
		s_d.retrain = 1'b0;  // RULE_17

		// Software writes to the control half; status bits in the word are ignored.
		if (wr_link) begin
			s_d.aspm = WR_DATA_IN[link_ctrl_pkg::ASPM_LO +: 2];  // RULE_01
			s_d.common_clk = WR_DATA_IN[link_ctrl_pkg::COMMON_CLK_BIT];  // RULE_07
			s_d.ext_sync = WR_DATA_IN[link_ctrl_pkg::EXT_SYNC_BIT];
			s_d.auto_width = WR_DATA_IN[link_ctrl_pkg::AUTO_WIDTH_BIT];
			// The upstream port may neither disable nor retrain its own link.
			if (!IS_UPSTREAM) begin
				s_d.link_dis = WR_DATA_IN[link_ctrl_pkg::LINK_DIS_BIT];  // RULE_04
				s_d.retrain = WR_DATA_IN[link_ctrl_pkg::RETRAIN_BIT];  // RULE_05 RULE_17
				s_d.dsp_ctrl = WR_DATA_IN[link_ctrl_pkg::DSP_CTRL_LO +: 2];  // RULE_09
			end
		end

		// Extended synchronisation lengthens the exit sequences.
		s_d.fts_cnt = s_d.ext_sync ? link_ctrl_pkg::EXT_FTS_COUNT : BASE_FTS;  // RULE_08
		s_d.ts1_cnt = s_d.ext_sync ? link_ctrl_pkg::EXT_TS1_COUNT : BASE_TS1;  // RULE_08

		// The receiver keeps L0s whatever the control field says.
		s_d.rx_l0s = 1'b1;  // RULE_02

		// Status follows the link logic; a change of rate or width is an event.
		s_d.speed = LINK_SPEED_IN;  // RULE_10
		s_d.width = LINK_WIDTH_IN;  // RULE_11
		events[link_ctrl_pkg::EV_RATE_CHG] = (LINK_SPEED_IN != s_q.speed) ||
			(LINK_WIDTH_IN != s_q.width);
		s_d.training = TRAIN_ACTIVE_IN;  // RULE_13

		// Training error: a failure wins over a success in the same cycle.
		if (TRAIN_FAIL_IN) begin
			s_d.train_err = 1'b1;  // RULE_12
		end else if (TRAIN_OK_IN) begin
			s_d.train_err = 1'b0;  // RULE_12
		end
		events[link_ctrl_pkg::EV_TRAIN_ERR] = TRAIN_FAIL_IN;
		events[link_ctrl_pkg::EV_TRAIN_DONE] = TRAIN_OK_IN;

		s_d.dl_active = DL_ACTIVE_IN;  // RULE_16
		events[link_ctrl_pkg::EV_DL_CHANGE] = DL_ACTIVE_IN != s_q.dl_active;

		// Strap synchroniser; only the second stage is looked at.
		s_d.strap_s1 = SLOT_CLOCK_STRAP_IN;
		s_d.strap_s2 = s_q.strap_s1;
		if (s_q.strap_cnt != link_ctrl_pkg::STRAP_SETTLE) begin
			s_d.strap_cnt = s_q.strap_cnt + 2'h1;
		end

		// The strap value is taken once it has settled; a later load replaces it.
		if (SLOT_CLK_LOAD_IN) begin
			s_d.slot_clk = SLOT_CLK_VAL_IN;  // RULE_15
		end else if (s_q.strap_cnt == (link_ctrl_pkg::STRAP_SETTLE - 2'h1)) begin
			s_d.slot_clk = s_q.strap_s2;  // RULE_14
		end

		// Event enables.
		if (wr_enable) begin
			s_d.ev_enable = WR_DATA_IN[link_ctrl_pkg::EV_COUNT-1:0];
		end

		// Sticky events: a new event wins over a clear in the same cycle.
		if (wr_clear) begin
			s_d.ev_status = s_q.ev_status & ~WR_DATA_IN[link_ctrl_pkg::EV_COUNT-1:0];
		end
		s_d.ev_status = s_d.ev_status | events;
		s_d.irq = |(s_d.ev_status & s_d.ev_enable);

		// Read data stand only in the cycle after the strobe; unmapped reads give zero.
		s_d.rd_data = 32'h0000_0000;
		if (RD_IN) begin
			case (ADDR_IN)
				link_ctrl_pkg::LINK_CTRL_STAT_ADDR: begin
					s_d.rd_data = link_word(s_q);  // RULE_03 RULE_06
				end
				link_ctrl_pkg::IRQ_STATUS_ADDR: begin
					s_d.rd_data = {28'h0000000, s_q.ev_status};
				end
				link_ctrl_pkg::IRQ_ENABLE_ADDR: begin
					s_d.rd_data = {28'h0000000, s_q.ev_enable};
				end
				default: begin
					s_d.rd_data = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register; reset loads constants only.
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			s_q <= '0;
			s_q.aspm <= link_ctrl_pkg::ASPM_RESET;  // RULE_01
			s_q.speed <= link_ctrl_pkg::SPEED_RESET;  // RULE_10
			s_q.width <= link_ctrl_pkg::WIDTH_RESET;  // RULE_11
			s_q.rx_l0s <= 1'b1;
			s_q.fts_cnt <= BASE_FTS;
			s_q.ts1_cnt <= BASE_TS1;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs straight from the state flip-flops.
	assign RD_DATA_OUT        = s_q.rd_data;
	assign ASPM_L0S_EN_OUT    = s_q.aspm[0];
	assign ASPM_L1_EN_OUT     = s_q.aspm[1];
	assign RX_L0S_ALLOWED_OUT = s_q.rx_l0s;
	assign LINK_DISABLE_OUT   = s_q.link_dis;
	assign RETRAIN_REQ_OUT    = s_q.retrain;
	assign COMMON_CLK_OUT     = s_q.common_clk;
	assign AUTO_WIDTH_DIS_OUT = s_q.auto_width;
	assign FTS_COUNT_OUT      = s_q.fts_cnt;
	assign TS1_COUNT_OUT      = s_q.ts1_cnt;
	assign SLOT_CLK_OUT       = s_q.slot_clk;
	assign IRQ_OUT            = s_q.irq;

endmodule

// file: sim/link_train_model.sv
// Behavioural link training partner: trains the link after each retrain request.
// Assumes the register bank clock and reset; the bench picks outcome, rate and length.
`timescale 1ns/1ns
module link_train_model (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       retrain_in,  // One-cycle request from the port.
	input  wire logic       fail_in,     // The next training fails when high.
	input  wire logic       fast_in,     // The next training reaches the higher rate.
	input  wire logic [7:0] len_in,      // Training length, prompt or slow.
	output logic            active_out,
	output logic            ok_out,
	output logic            bad_out,
	output logic            dl_out,
	output logic      [3:0] speed_out
);
	logic [7:0] cnt;  // Cycles of training left.
	// Training holds its level, then gives one result pulse; the link drops meanwhile.
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			{active_out, ok_out, bad_out, dl_out, cnt} <= '0;
			speed_out <= 4'h2;
		end else begin
			ok_out <= 1'b0;
			bad_out <= 1'b0;
			if (retrain_in) begin
				active_out <= 1'b1;
				dl_out <= 1'b0;
				cnt <= len_in;
			end else if (active_out && cnt == 8'h00) begin
				active_out <= 1'b0;
				ok_out <= !fail_in;
				bad_out <= fail_in;
				dl_out <= !fail_in;
				speed_out <= fail_in ? speed_out : (fast_in ? 4'h2 : 4'h1);
			end else if (active_out) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// file: sim/link_ctrl_props.sv
// Port assertions for the link control and status register bank.
// Assumes a bind to every instance; reads are judged by the word that comes back.
`timescale 1ns/1ns
module link_ctrl_props #(
	parameter bit IS_UPSTREAM = 1'b0
) (
	input wire logic        CLK_IN,
	input wire logic        SYS_RST_IN,
	input wire logic [7:0]  ADDR_IN,
	input wire logic [31:0] WR_DATA_IN,
	input wire logic        WR_IN,
	input wire logic        RD_IN,
	input wire logic [31:0] RD_DATA_OUT,
	input wire logic        TRAIN_FAIL_IN,
	input wire logic        TRAIN_OK_IN,
	input wire logic        DL_ACTIVE_IN,
	input wire logic        ASPM_L0S_EN_OUT,
	input wire logic        ASPM_L1_EN_OUT,
	input wire logic        RX_L0S_ALLOWED_OUT,
	input wire logic        LINK_DISABLE_OUT,
	input wire logic        RETRAIN_REQ_OUT,
	input wire logic [12:0] FTS_COUNT_OUT,
	input wire logic [12:0] TS1_COUNT_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	logic        wr_w;  // Write to the control and status word.
	logic        rd_w;  // Read of the control and status word.
	logic [31:0] wd_q;  // Write data of the previous cycle.
	logic        err_q; // Expected training error flag.
	assign wr_w = WR_IN && ADDR_IN == link_ctrl_pkg::LINK_CTRL_STAT_ADDR;
	assign rd_w = RD_IN && ADDR_IN == link_ctrl_pkg::LINK_CTRL_STAT_ADDR;
	// A failure wins over a success in the same cycle, so it is tested first.
	always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			err_q <= 1'b0;
		end else begin
			err_q <= TRAIN_FAIL_IN ? 1'b1 : (TRAIN_OK_IN ? 1'b0 : err_q);
			wd_q <= WR_DATA_IN;
		end
	end
	a_aspm_follows_write: assert property (wr_w |=> {ASPM_L1_EN_OUT, ASPM_L0S_EN_OUT} == wd_q[1:0])
		else $error("power control differs from the write");
	a_rx_l0s_kept: assert property (RX_L0S_ALLOWED_OUT)
		else $error("receiver standby entry withdrawn");
	a_boundary_reads_zero: assert property (rd_w |=> !RD_DATA_OUT[3])
		else $error("completion boundary bit read as one");
	a_disable_follows_write: assert property (wr_w |=> LINK_DISABLE_OUT == (!IS_UPSTREAM && wd_q[4]))
		else $error("link disable differs from the write");
	a_retrain_one_pulse: assert property (wr_w && WR_DATA_IN[5] && !IS_UPSTREAM |=> RETRAIN_REQ_OUT ##1 !RETRAIN_REQ_OUT)
		else $error("retrain request is not one cycle");
	a_retrain_has_cause: assert property (RETRAIN_REQ_OUT |-> !IS_UPSTREAM && $past(wr_w) && wd_q[5])
		else $error("retrain request without a write");
	a_retrain_reads_zero: assert property (rd_w |=> !RD_DATA_OUT[5])
		else $error("retrain bit read as one");
	a_ext_sync_counts: assert property (wr_w && WR_DATA_IN[7] |=> FTS_COUNT_OUT == 13'h1000 && TS1_COUNT_OUT == 13'h0400)
		else $error("extended sync counts wrong");
	a_upstream_bits_zero: assert property (rd_w && IS_UPSTREAM |=> RD_DATA_OUT[11:10] == 2'h0)
		else $error("upstream storage bits read nonzero");
	a_train_err_flag: assert property (rd_w |=> RD_DATA_OUT[26] == $past(err_q))
		else $error("training error flag wrong");
	a_dl_active_bit: assert property (rd_w && $stable(DL_ACTIVE_IN) |=> RD_DATA_OUT[29] == $past(DL_ACTIVE_IN))
		else $error("link active bit wrong");
	c_retrain: cover property (wr_w && WR_DATA_IN[5]);
	c_err_read: cover property (rd_w ##1 RD_DATA_OUT[26]);
	c_upstream_read: cover property (rd_w && IS_UPSTREAM);
endmodule
bind link_ctrl_regs link_ctrl_props #(.IS_UPSTREAM(IS_UPSTREAM)) i_props (.*);

// file: sim/testbench.sv
// Self-checking bench: a downstream and an upstream bank share one partner and one bus.
// Assumes the package constants; reads are queued and judged by a watcher process.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module testbench;
	logic CLK_IN, SYS_RST_IN, WR_IN, RD_IN, TRAIN_ACTIVE_IN, TRAIN_FAIL_IN, TRAIN_OK_IN, DL_ACTIVE_IN;
	logic SLOT_CLOCK_STRAP_IN, SLOT_CLK_LOAD_IN, SLOT_CLK_VAL_IN, ASPM_L0S_EN_OUT, ASPM_L1_EN_OUT;
	logic RX_L0S_ALLOWED_OUT, LINK_DISABLE_OUT, RETRAIN_REQ_OUT, COMMON_CLK_OUT, AUTO_WIDTH_DIS_OUT;
	logic SLOT_CLK_OUT, IRQ_OUT, up_rt, up_dis, fail_m, fast_m, slot_m, err_m, rd_q;
	logic [7:0]  ADDR_IN, len_m;
	logic [31:0] WR_DATA_IN, RD_DATA_OUT, up_rdat, d, e;
	logic [3:0]  LINK_SPEED_IN, sp_p, ev_m, en_m;
	logic [5:0]  LINK_WIDTH_IN, wd_p;
	logic [12:0] FTS_COUNT_OUT, TS1_COUNT_OUT;
	logic [15:0] ctrl_m;     // Expected control half.
	logic        dl_p;       // Link active level seen last cycle.
	logic [31:0] expq[$];    // Expected read words, oldest first.
	int n_errors = 0;
	int total_checks = 0;
	link_ctrl_regs i_dut (.*);
	link_ctrl_regs #(.IS_UPSTREAM(1'b1)) i_up (.*, .RD_DATA_OUT(up_rdat), .RETRAIN_REQ_OUT(up_rt),
		.LINK_DISABLE_OUT(up_dis), .ASPM_L0S_EN_OUT(), .ASPM_L1_EN_OUT(), .RX_L0S_ALLOWED_OUT(),
		.COMMON_CLK_OUT(), .AUTO_WIDTH_DIS_OUT(), .FTS_COUNT_OUT(), .TS1_COUNT_OUT(), .SLOT_CLK_OUT(),
		.IRQ_OUT());
	link_train_model i_far (.clk_in(CLK_IN), .rst_in(SYS_RST_IN), .retrain_in(RETRAIN_REQ_OUT),
		.fail_in(fail_m), .fast_in(fast_m), .len_in(len_m), .active_out(TRAIN_ACTIVE_IN),
		.ok_out(TRAIN_OK_IN), .bad_out(TRAIN_FAIL_IN), .dl_out(DL_ACTIVE_IN), .speed_out(LINK_SPEED_IN));
	initial begin
		CLK_IN = 1'b0;
		forever #25 CLK_IN = ~CLK_IN;
	end
	// Status word as the inputs say it should read once they have settled.
	function automatic logic [31:0] dword();
		return {2'h0, DL_ACTIVE_IN, slot_m, TRAIN_ACTIVE_IN, err_m, LINK_WIDTH_IN, LINK_SPEED_IN, ctrl_m};
	endfunction
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		ADDR_IN <= a;
		WR_DATA_IN <= v;
		WR_IN <= 1'b1;
		@(posedge CLK_IN);
		WR_IN <= 1'b0;
	endtask
	task automatic rd32(input logic [7:0] a, input logic [31:0] v);
		ADDR_IN <= a;
		RD_IN <= 1'b1;
		expq.push_back(v);
		@(posedge CLK_IN);
		RD_IN <= 1'b0;
	endtask
	// Retrain, read while training runs, then read the outcome once the link is quiet.
	task automatic train(input logic f, input logic [7:0] n);
		fail_m <= f;
		len_m <= n;
		wr32(8'hD0, {16'h0000, ctrl_m | 16'h0020});
		repeat (4) @(posedge CLK_IN);
		rd32(8'hD0, dword());
		for (int k = 0; k < 300 && TRAIN_ACTIVE_IN; k++) @(posedge CLK_IN);
		repeat (3) @(posedge CLK_IN);
		rd32(8'hD0, dword());
	endtask
	// Mirror of the sticky flags; a clear loses to an event in the same cycle.
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			{err_m, ev_m, dl_p, sp_p, wd_p} = {1'b0, 4'h0, 1'b0, 4'h2, 6'h01};
		end else begin
			err_m = TRAIN_FAIL_IN ? 1'b1 : (TRAIN_OK_IN ? 1'b0 : err_m);
			if (WR_IN && ADDR_IN == 8'hE4) ev_m = ev_m & ~WR_DATA_IN[3:0];
			ev_m = ev_m | {LINK_SPEED_IN != sp_p || LINK_WIDTH_IN != wd_p, DL_ACTIVE_IN != dl_p, TRAIN_OK_IN,
				TRAIN_FAIL_IN};
			{dl_p, sp_p, wd_p} = {DL_ACTIVE_IN, LINK_SPEED_IN, LINK_WIDTH_IN};
		end
	end
	// Each read answer is matched to the oldest queued note; upstream drops bits 4, 11:10.
	always @(posedge CLK_IN) begin
		if (rd_q) begin
			e = expq.pop_front();
			`CHK("read word", e, RD_DATA_OUT)
			`CHK("upstream word", e & ~32'h0C10, up_rdat)
		end
		`CHK("upstream retrain", 1'b0, up_rt)
		`CHK("upstream disable", 1'b0, up_dis)
		rd_q <= RD_IN;
	end
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// A hang is cut short well beyond the roughly 120 cycles the run needs.
	initial begin
		repeat (5000) @(posedge CLK_IN);
		n_errors++;
		summarize();
	end
	initial begin
		{SYS_RST_IN, SLOT_CLOCK_STRAP_IN, fast_m} = 3'b111;
		{WR_IN, RD_IN, SLOT_CLK_LOAD_IN, SLOT_CLK_VAL_IN, fail_m, rd_q, slot_m} = '0;
		{ADDR_IN, WR_DATA_IN, ctrl_m, en_m, len_m} = '0;
		LINK_WIDTH_IN = 6'h01;
		void'($urandom(53156));
		repeat (5) @(posedge CLK_IN);
		SYS_RST_IN <= 1'b0;
		repeat (4) @(posedge CLK_IN);
		slot_m = 1'b1;
		rd32(8'hD0, dword());
		`CHK("rx standby", 1'b1, RX_L0S_ALLOWED_OUT)
		// Every power-control code, with random neighbours but no retrain.
		for (int i = 0; i < 8; i++) begin
			d = $urandom & 32'hFFFF_FFDF;
			d[1:0] = i[1:0];
			wr32(8'hD0, d);
			ctrl_m = d[15:0] & 16'h0ED3;
			rd32(8'hD0, dword());
			`CHK("power control", d[1:0], {ASPM_L1_EN_OUT, ASPM_L0S_EN_OUT})
			`CHK("fts count", d[7] ? 13'h1000 : 13'h0080, FTS_COUNT_OUT)
			`CHK("ts1 count", d[7] ? 13'h0400 : 13'h0010, TS1_COUNT_OUT)
			`CHK("common clock", d[6], COMMON_CLK_OUT)
			`CHK("link disable", d[4], LINK_DISABLE_OUT)
			`CHK("auto width", d[9], AUTO_WIDTH_DIS_OUT)
		end
		train(1'b0, 8'd20);
		train(1'b1, 8'd10);
		LINK_WIDTH_IN <= 6'h04;
		fast_m <= 1'b0;
		train(1'b0, 8'd8);
		wr32(8'hE4, 32'h0000_000F);
		@(posedge CLK_IN);
		wr32(8'hE8, 32'h0000_0000);
		@(posedge CLK_IN);
		train(1'b1, 8'd8);
		`CHK("masked irq", 1'b0, IRQ_OUT)
		wr32(8'hE8, 32'h0000_0001);
		en_m = 4'h1;
		rd32(8'hE0, {28'h0, ev_m});
		`CHK("irq", |(ev_m & en_m), IRQ_OUT)
		wr32(8'hE4, 32'h0000_0001);
		rd32(8'h44, 32'h0);
		@(posedge CLK_IN);
		rd32(8'hE4, 32'h0);
		`CHK("cleared irq", 1'b0, IRQ_OUT)
		SLOT_CLK_LOAD_IN <= 1'b1;
		@(posedge CLK_IN);
		SLOT_CLK_LOAD_IN <= 1'b0;
		slot_m = 1'b0;
		repeat (2) @(posedge CLK_IN);
		rd32(8'hD0, dword());
		`CHK("slot clock", 1'b0, SLOT_CLK_OUT)
		repeat (2) @(posedge CLK_IN);
		summarize();
	end
endmodule
